// ==== omd_cpu_model.sv ====
// Purpose: CPU side that issues one request and waits for its answer.
// Assumes: Signals change at the falling edge.
// Notes: Released address and data lines show the inverse of the last value.
`default_nettype none
module omd_cpu_model (
  input wire logic clk_sys,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic rsp_error,
  input wire logic [31:0] rsp_rdata,
  output var logic req_valid,
  output var logic req_fetch,
  output var logic req_write,
  output var logic [1:0] req_size,
  output var logic [31:0] req_addr,
  output var logic [31:0] req_wdata
);
  initial begin
    req_valid = 1'b0;
    req_fetch = 1'b0;
    req_write = 1'b0;
    req_size = 2'h0;
    req_addr = 32'h0;
    req_wdata = 32'h0;
  end
  task automatic access(input logic f, input logic w, input logic [1:0] sz,
    input logic [31:0] a, input logic [31:0] d, output logic [31:0] rd,
    output logic er, output logic to);
    int k;
    to = 1'b1;
    rd = 32'h0;
    er = 1'b0;
    @(negedge clk_sys);
    req_valid = 1'b1;
    req_fetch = f && (a[23:12] != 12'hfff);
    req_write = w;
    req_size = sz;
    req_addr = a;
    req_wdata = d;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (!req_ready && k < 8);
    @(negedge clk_sys);
    req_valid = 1'b0;
    req_addr = ~a;
    req_wdata = ~d;
    for (k = 0; k < 4 && to; k++) begin
      if (rsp_valid === 1'b1) begin
        rd = rsp_rdata;
        er = rsp_error;
        to = 1'b0;
      end else @(negedge clk_sys);
    end
  endtask
endmodule // omd_cpu_model
`default_nettype wire

// ==== omd_decoder.v ====
// Purpose: On-chip memory map decoder between CPU core and memories.
// Assumes: One request per cycle when idle; peripheral words take two cycles.
// Notes: All outputs are registered; answers appear one edge after the last select, error answers at the accepting edge.
`include "omd_regs.vh"
`default_nettype none
module omd_decoder (
  input wire clk_sys,
  input wire nrst,
  input wire [1:0] rom_cfg,
  input wire ram_8k,
  input wire ext_enable,
  input wire req_valid,
  input wire req_fetch,
  input wire req_write,
  input wire [1:0] req_size,
  input wire [31:0] req_addr,
  input wire [31:0] req_wdata,
  output reg req_ready,
  output reg rsp_valid,
  output reg rsp_error,
  output reg [31:0] rsp_rdata,
  input wire irq_accept,
  input wire [5:0] irq_source,
  output reg redirect_valid,
  output reg [23:0] redirect_addr,
  output reg rom_sel,
  output reg ram_sel,
  output reg ext_sel,
  output reg [23:0] mem_addr,
  output reg mem_write,
  output reg [1:0] mem_size,
  output reg [31:0] mem_wdata,
  input wire [31:0] rom_rdata,
  input wire [31:0] ram_rdata,
  input wire [31:0] ext_rdata,
  output reg peri_sel,
  output reg [9:0] peri_addr,
  output reg peri_write,
  output reg peri_byte_reg_half,
  output reg [15:0] peri_wdata,
  input wire [15:0] peri_rdata,
  input wire peri_byte_only
);
  localparam ST_IDLE = 2'h0;
  localparam ST_SECOND = 2'h1;
  localparam ST_DONE = 2'h2;

  reg [1:0] state_reg;
  reg [15:0] low_half_reg;
  reg [15:0] high_wdata_reg;
  reg [2:0] last_tgt_reg;
  wire [23:0] offset;
  wire [2:0] target;
  wire [23:0] vec_entry;

  assign offset = req_addr[23:0];

  omd_region u_region (
    .offset(offset),
    .rom_cfg(rom_cfg),
    .ram_8k(ram_8k),
    .ext_enable(ext_enable),
    .target(target)
  );

  omd_vector u_vector (
    .source(irq_source),
    .entry(vec_entry)
  );

  // Peripheral index: 1 KB image with bit 0 dropped.
  // The mask is applied at full offset width and then cut to the image size.
  function [9:0] peri_index;
    input [23:0] addr;
    reg [23:0] masked;
    begin
      masked = addr & `OMD_PERI_MASK;
      peri_index = masked[9:0];
    end
  endfunction

  // Shapes peripheral read data by the width of the original access.
  // A word joins the two halfword cycles, high half from the second one.
  // Narrow reads clear the bits that the register does not define.
  function [31:0] shape_peri;
    input [1:0] size;
    input byte_half;
    input [15:0] hi;
    input [15:0] lo;
    begin
      if (size == `OMD_SZ_WORD) begin
        shape_peri = {hi, lo};
      // undefined upper byte reads as zero
      end else if (byte_half || (size == `OMD_SZ_BYTE)) begin
        shape_peri = {24'h0, hi[7:0]};
      end else begin
        shape_peri = {16'h0, hi};
      end
    end
  endfunction

  // Return data of the previous cycle's target.
  function [31:0] pick_rdata;
    input [2:0] tgt;
    input [31:0] rom_d;
    input [31:0] ram_d;
    input [31:0] ext_d;
    begin
      case (tgt)
        `OMD_TGT_ROM: pick_rdata = rom_d;
        `OMD_TGT_RAM: pick_rdata = ram_d;
        `OMD_TGT_EXT: pick_rdata = ext_d;
        default: pick_rdata = 32'h0;
      endcase
    end
  endfunction

  always @(posedge clk_sys) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_error <= 1'b0;
      rsp_rdata <= 32'h0;
      redirect_valid <= 1'b0;
      redirect_addr <= 24'h0;
      rom_sel <= 1'b0;
      ram_sel <= 1'b0;
      ext_sel <= 1'b0;
      mem_addr <= 24'h0;
      mem_write <= 1'b0;
      mem_size <= 2'h0;
      mem_wdata <= 32'h0;
      peri_sel <= 1'b0;
      peri_addr <= 10'h0;
      peri_write <= 1'b0;
      peri_byte_reg_half <= 1'b0;
      peri_wdata <= 16'h0;
      low_half_reg <= 16'h0;
      high_wdata_reg <= 16'h0;
      last_tgt_reg <= `OMD_TGT_NONE;
    end else begin
      rsp_valid <= 1'b0;
      rsp_error <= 1'b0;
      rom_sel <= 1'b0;
      ram_sel <= 1'b0;
      ext_sel <= 1'b0;
      peri_sel <= 1'b0;
      peri_write <= 1'b0;
      mem_write <= 1'b0;
      peri_byte_reg_half <= 1'b0;
      redirect_valid <= 1'b0;
      last_tgt_reg <= `OMD_TGT_NONE;
      if (irq_accept) begin
        redirect_valid <= 1'b1;
        redirect_addr <= vec_entry;
      end
      case (state_reg)
        ST_IDLE: begin
          req_ready <= 1'b1;
          if (req_valid && req_ready) begin
            mem_addr <= offset;
            mem_size <= req_size;
            mem_wdata <= req_wdata;
            case (target)
              `OMD_TGT_ROM: begin
                rom_sel <= 1'b1;
                mem_write <= req_write;
                last_tgt_reg <= target;
                state_reg <= ST_DONE;
                req_ready <= 1'b0;
              end
              `OMD_TGT_RAM: begin
                ram_sel <= 1'b1;
                mem_write <= req_write;
                last_tgt_reg <= target;
                state_reg <= ST_DONE;
                req_ready <= 1'b0;
              end
              `OMD_TGT_EXT: begin
                ext_sel <= 1'b1;
                mem_write <= req_write;
                last_tgt_reg <= target;
                state_reg <= ST_DONE;
                req_ready <= 1'b0;
              end
              `OMD_TGT_PERI: begin
                // fetch into peripheral area is flagged
                if (req_fetch) begin
                  rsp_valid <= 1'b1;
                  rsp_error <= 1'b1;
                  rsp_rdata <= 32'h0;
                end else begin
                  peri_sel <= 1'b1;
                  peri_addr <= peri_index(offset);
                  peri_write <= req_write;
                  peri_wdata <= req_wdata[15:0];
                  peri_byte_reg_half <= peri_byte_only && (req_size == `OMD_SZ_HALF);
                  high_wdata_reg <= req_wdata[31:16];
                  req_ready <= 1'b0;
                  if (req_size == `OMD_SZ_WORD) begin
                    state_reg <= ST_SECOND;
                  end else begin
                    state_reg <= ST_DONE;
                    last_tgt_reg <= `OMD_TGT_PERI;
                  end
                end
              end
              default: begin
                // hole answers with error, write dropped
                rsp_valid <= 1'b1;
                rsp_error <= 1'b1;
                rsp_rdata <= 32'h0;
              end
            endcase
          end
        end
        ST_SECOND: begin
          low_half_reg <= peri_rdata;
          peri_sel <= 1'b1;
          peri_addr <= peri_addr + 10'h2;
          peri_write <= peri_write;
          peri_wdata <= high_wdata_reg;
          last_tgt_reg <= `OMD_TGT_PERI;
          state_reg <= ST_DONE;
        end
        ST_DONE: begin
          rsp_valid <= 1'b1;
          // The peripheral answers one cycle after its last select.
          // Memories answer one cycle after their select as well.
          if (last_tgt_reg == `OMD_TGT_PERI) begin
            rsp_rdata <= shape_peri(mem_size, peri_byte_reg_half, peri_rdata, low_half_reg);
          end else begin
            rsp_rdata <= pick_rdata(last_tgt_reg, rom_rdata, ram_rdata, ext_rdata);
          end
          req_ready <= 1'b1;
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // omd_decoder
`default_nettype wire

// ==== omd_decoder_monitor.sv ====
// Purpose: Port checks of the memory map decoder.
// Assumes: One clock, synchronous active-low reset.
// Notes: Bound to omd_decoder at the foot of this file.
`default_nettype none
module omd_decoder_monitor (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ext_enable,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic rsp_error,
  input wire logic [31:0] rsp_rdata,
  input wire logic irq_accept,
  input wire logic [5:0] irq_source,
  input wire logic redirect_valid,
  input wire logic [23:0] redirect_addr,
  input wire logic rom_sel,
  input wire logic ram_sel,
  input wire logic ext_sel,
  input wire logic [23:0] mem_addr,
  input wire logic peri_sel,
  input wire logic [9:0] peri_addr
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  property p_irq; irq_accept |=> redirect_valid; endproperty
  a_irq: assert property (p_irq)
    else $error("no redirect after accept");
  property p_vfix;
    irq_accept && irq_source < 6'h3 |=> redirect_addr == {14'h0, $past(irq_source), 4'h0};
  endproperty
  a_vfix: assert property (p_vfix)
    else $error("fixed entry wrong");
  property p_vstep;
    irq_accept && irq_source >= 6'h3 && irq_source <= 6'h20
      |=> redirect_addr == 24'h80 + {14'h0, $past(irq_source) - 6'h3, 4'h0};
  endproperty
  a_vstep: assert property (p_vstep)
    else $error("maskable entry wrong");
  property p_even; peri_sel |-> !peri_addr[0]; endproperty
  a_even: assert property (p_even)
    else $error("odd peripheral address");
  property p_pair; peri_sel && $past(peri_sel) |-> peri_addr == $past(peri_addr) + 10'h2; endproperty
  a_pair: assert property (p_pair)
    else $error("second half not at n+2");
  property p_rom; rom_sel |-> mem_addr < 24'h100000; endproperty
  a_rom: assert property (p_rom)
    else $error("rom select outside region");
  property p_ram; ram_sel |-> mem_addr >= 24'hffd000 && mem_addr <= 24'hffefff; endproperty
  a_ram: assert property (p_ram)
    else $error("ram select outside region");
  property p_ext;
    ext_sel |-> ext_enable && mem_addr >= 24'h100000 && mem_addr <= 24'hffbfff;
  endproperty
  a_ext: assert property (p_ext)
    else $error("bad external select");
  property p_errd; rsp_valid && rsp_error |-> rsp_rdata == 32'h0; endproperty
  a_errd: assert property (p_errd)
    else $error("error answer carries data");
  property p_take; req_valid && req_ready |=> !req_ready || (rsp_valid && rsp_error); endproperty
  a_take: assert property (p_take)
    else $error("ready after take");
  c_split: cover property (peri_sel ##1 peri_sel);
  c_ext: cover property (ext_sel);
  c_err: cover property (rsp_valid && rsp_error);
endmodule // omd_decoder_monitor
bind omd_decoder omd_decoder_monitor omd_decoder_monitor_inst (.clk_sys(clk_sys),
  .nrst(nrst), .ext_enable(ext_enable), .req_valid(req_valid), .req_ready(req_ready),
  .rsp_valid(rsp_valid), .rsp_error(rsp_error), .rsp_rdata(rsp_rdata),
  .irq_accept(irq_accept), .irq_source(irq_source), .redirect_valid(redirect_valid),
  .redirect_addr(redirect_addr), .rom_sel(rom_sel), .ram_sel(ram_sel), .ext_sel(ext_sel),
  .mem_addr(mem_addr), .peri_sel(peri_sel), .peri_addr(peri_addr));
`default_nettype wire

// ==== omd_decoder_tb_top.sv ====
// Purpose: Self-checking bench of the memory map decoder.
// Assumes: Memories answer with fixed words, registers with an address pattern.
// Notes: Reset first, then table rows, a split write, a dropped write and handler entries.
`default_nettype none
module omd_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [1:0] cfg; logic r8; logic ext; logic bo; logic [1:0] sz;
    logic [31:0] a; logic er; logic [31:0] ex;
  } omd_row_t;
  localparam omd_row_t rows [15] = '{
    '{0,0,0,0,2,32'h0000fffc,0,32'ha1a2a3a4}, '{0,0,0,0,2,32'h00010000,1,0},
    '{1,0,0,0,2,32'h0201fffc,0,32'ha1a2a3a4}, '{1,0,0,0,2,32'h00020000,1,0},
    '{2,0,0,0,2,32'h0003fffc,0,32'ha1a2a3a4}, '{2,0,0,0,2,32'h000ffffc,1,0},
    '{0,0,0,0,2,32'hffffdffc,1,0}, '{0,0,0,0,2,32'h00ffe000,0,32'hb1b2b3b4},
    '{0,1,0,0,2,32'h00ffd000,0,32'hb1b2b3b4}, '{0,1,0,0,2,32'h00ffcffc,1,0},
    '{0,0,0,0,2,32'h00100000,1,0}, '{0,0,1,0,2,32'h00100000,0,32'hc1c2c3c4},
    '{0,0,0,0,0,32'h00fff403,0,32'h02}, '{0,0,0,1,1,32'h00fff010,0,32'h10},
    '{0,0,0,0,2,32'h00fff404,0,32'he406ec04}};
  logic clk_sys = 0, nrst = 0, ram_8k = 0, ext_enable = 0, irq_accept = 0, peri_byte_only = 0;
  logic [1:0] rom_cfg = 0;
  logic [5:0] irq_source = 0;
  wire logic req_valid, req_fetch, req_write;
  wire logic [1:0] req_size;
  wire logic [31:0] req_addr, req_wdata;
  logic req_ready, rsp_valid, rsp_error, redirect_valid, peri_sel, er, to;
  logic [31:0] rsp_rdata, rd;
  logic [23:0] redirect_addr;
  logic [9:0] peri_addr;
  logic [15:0] peri_wdata;
  logic [25:0] pq [$];
  int n_errors = 0, num_checks = 0;
  wire logic [15:0] peri_rdata = {~peri_addr[5:0], peri_addr};
  always #25 clk_sys = ~clk_sys;
  always @(negedge clk_sys) if (peri_sel === 1'b1) pq.push_back({peri_addr, peri_wdata});
  omd_cpu_model omd_cpu_model_inst (.clk_sys(clk_sys), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_error(rsp_error), .rsp_rdata(rsp_rdata),
    .req_valid(req_valid), .req_fetch(req_fetch), .req_write(req_write),
    .req_size(req_size), .req_addr(req_addr), .req_wdata(req_wdata));
  omd_decoder omd_decoder_inst (.clk_sys(clk_sys), .nrst(nrst), .rom_cfg(rom_cfg),
    .ram_8k(ram_8k), .ext_enable(ext_enable), .req_valid(req_valid), .req_fetch(req_fetch),
    .req_write(req_write), .req_size(req_size), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_error(rsp_error),
    .rsp_rdata(rsp_rdata), .irq_accept(irq_accept), .irq_source(irq_source),
    .redirect_valid(redirect_valid), .redirect_addr(redirect_addr), .rom_sel(),
    .ram_sel(), .ext_sel(), .mem_addr(), .mem_write(), .mem_size(), .mem_wdata(),
    .rom_rdata(32'ha1a2a3a4), .ram_rdata(32'hb1b2b3b4), .ext_rdata(32'hc1c2c3c4),
    .peri_sel(peri_sel), .peri_addr(peri_addr), .peri_write(), .peri_byte_reg_half(),
    .peri_wdata(peri_wdata), .peri_rdata(peri_rdata), .peri_byte_only(peri_byte_only));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic test_done();
    $display("errors %0d checks %0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic acc(input logic w, input logic [1:0] sz, input logic [31:0] a,
    input logic [31:0] d);
    omd_cpu_model_inst.access(1'b0, w, sz, a, d, rd, er, to);
    if (to) begin
      n_errors++;
      test_done();
    end
  endtask
  initial begin
    repeat (6) @(negedge clk_sys);
    chk({31'h0, req_ready}, 32'h0);
    nrst = 1'b1;
    @(negedge clk_sys);
    chk({31'h0, req_ready}, 32'h1);
    for (int i = 0; i < 15; i++) begin
      rom_cfg = rows[i].cfg;
      ram_8k = rows[i].r8;
      ext_enable = rows[i].ext;
      peri_byte_only = rows[i].bo;
      acc(1'b0, rows[i].sz, rows[i].a, 32'h0);
      chk({31'h0, er}, {31'h0, rows[i].er});
      chk(rd, rows[i].ex);
    end
    pq.delete();
    acc(1'b1, 2'h2, 32'h00fff100, 32'h12345678);
    chk(pq.size(), 32'h2);
    chk({6'h0, pq[0]}, 32'h01005678);
    chk({6'h0, pq[1]}, 32'h01021234);
    pq.delete();
    acc(1'b1, 2'h2, 32'h00010000, 32'h55aa55aa);
    chk({31'h0, er}, 32'h1);
    chk(pq.size(), 32'h0);
    for (int i = 0; i < 6; i++) begin
      @(negedge clk_sys);
      irq_accept = 1'b1;
      irq_source = 6'(i < 5 ? i : 40);
      @(negedge clk_sys);
      irq_accept = 1'b0;
      chk({31'h0, redirect_valid}, 32'h1);
      chk({8'h0, redirect_addr}, i < 3 ? i * 16 : (i < 5 ? 32'h50 + i * 16 : 32'h250));
    end
    test_done();
  end
endmodule // omd_decoder_tb_top
`default_nettype wire

// ==== omd_region.v ====
// Purpose: Combinational region lookup of one 24-bit physical offset.
// Assumes: Upper CPU address bits were already dropped.
// Notes: Holes decode to the error target.
`include "omd_regs.vh"
`default_nettype none
module omd_region (
  input wire [23:0] offset,
  input wire [1:0] rom_cfg,
  input wire ram_8k,
  input wire ext_enable,
  output reg [2:0] target
);
  reg [23:0] rom_end;
  reg [23:0] ram_base;
  always @* begin
    case (rom_cfg)
      `OMD_ROM_CFG_64K: rom_end = `OMD_ROM_END_64K;
      `OMD_ROM_CFG_128K: rom_end = `OMD_ROM_END_128K;
      default: rom_end = `OMD_ROM_END_256K;
    endcase
    ram_base = ram_8k ? `OMD_RAM_BASE_8K : `OMD_RAM_BASE_4K;
    if (offset >= `OMD_PERI_BASE) begin
      target = `OMD_TGT_PERI;
    end else if (offset >= ram_base && offset <= `OMD_RAM_END) begin
      target = `OMD_TGT_RAM;
    end else if (offset >= `OMD_HOLE_BASE) begin
      target = `OMD_TGT_ERR;
    end else if (offset < rom_end) begin
      target = `OMD_TGT_ROM;
    end else if (offset < `OMD_ROM_LIMIT) begin
      target = `OMD_TGT_ERR;
    end else if (ext_enable) begin
      target = `OMD_TGT_EXT;
    end else begin
      target = `OMD_TGT_ERR;
    end
  end
endmodule // omd_region
`default_nettype wire

// ==== omd_regs.vh ====
// Purpose: Constants of the on-chip memory map decoder.
// Assumes: Offsets are 24-bit physical offsets within a 16 MB block.
// Notes: Included by every design file of the decoder.
`ifndef OMD_REGS_VH
`define OMD_REGS_VH
`define OMD_ROM_LIMIT 24'h100000
`define OMD_ROM_END_64K 24'h010000
`define OMD_ROM_END_128K 24'h020000
`define OMD_ROM_END_256K 24'h040000
`define OMD_EXT_BASE 24'h100000
`define OMD_EXT_END 24'hffbfff
`define OMD_HOLE_BASE 24'hffc000
`define OMD_RAM_BASE_8K 24'hffd000
`define OMD_RAM_BASE_4K 24'hffe000
`define OMD_RAM_END 24'hffefff
`define OMD_PERI_BASE 24'hfff000
`define OMD_PERI_MASK 24'h0003fe
`define OMD_VEC_RESET 24'h000000
`define OMD_VEC_NMI 24'h000010
`define OMD_VEC_WDT 24'h000020
`define OMD_VEC_MASK_BASE 24'h000080
`define OMD_VEC_LAST 24'h000250
`define OMD_VEC_STEP 5'h10
`define OMD_ROM_CFG_64K 2'h0
`define OMD_ROM_CFG_128K 2'h1
`define OMD_ROM_CFG_256K 2'h2
`define OMD_TGT_NONE 3'h0
`define OMD_TGT_ROM 3'h1
`define OMD_TGT_RAM 3'h2
`define OMD_TGT_PERI 3'h3
`define OMD_TGT_EXT 3'h4
`define OMD_TGT_ERR 3'h5
`define OMD_SZ_BYTE 2'h0
`define OMD_SZ_HALF 2'h1
`define OMD_SZ_WORD 2'h2
`endif

// ==== omd_vector.v ====
// Purpose: Handler entry address of an accepted interrupt or exception.
// Assumes: Source code 0 reset, 1 NMI, 2 watchdog, 3 and up maskable.
// Notes: Maskable index 0 maps to the first maskable entry.
`include "omd_regs.vh"
`default_nettype none
module omd_vector (
  input wire [5:0] source,
  output reg [23:0] entry
);
  reg [23:0] step;
  always @* begin
    step = {18'h0, source} - 24'h3;
    case (source)
      6'h00: entry = `OMD_VEC_RESET;
      6'h01: entry = `OMD_VEC_NMI;
      6'h02: entry = `OMD_VEC_WDT;
      default: begin
        entry = `OMD_VEC_MASK_BASE + {step[19:0], 4'h0};
        if (entry > `OMD_VEC_LAST) begin
          entry = `OMD_VEC_LAST;
        end
      end
    endcase
  end
endmodule // omd_vector
`default_nettype wire
